// ===== bench/ssb_ctl_model.sv
`timescale 1ns/100ps
module ssb_ctl_model (
  // Clock.
  input wire logic clk,
  // Burst order strap level.
  input wire logic order,
  // Pins towards the memory.
  output ssb_pkg::ssb_pins_s pins
);
  import ssb_pkg::*;

  ssb_word_t wd_q;

  initial begin
    pins = '0;
    pins.clock_enable_n = 1'b1;
    wd_q = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bus cycle; write data goes out one cycle after its address.
  // The bench changes the strap only while the device is in reset.
  task automatic cycle(input logic ce_n, input logic ld_n, input logic rw_n,
      input logic cs_n, input ssb_addr_t a, input logic [LANES-1:0] bw, input ssb_word_t wd);
    @(posedge clk);
    pins.clock_enable_n <= ce_n;
    pins.advance_or_load_n <= ld_n;
    pins.read_write_n <= rw_n;
    pins.chip_select_n <= cs_n;
    pins.address <= a;
    pins.lane_write_enable_n <= bw;
    pins.burst_order_select <= order;
    pins.data <= wd_q;
    wd_q = wd;
  endtask
endmodule

// ===== bench/sync_sram_burst_cycle_control_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sync_sram_burst_cycle_control_test;
  import ssb_pkg::*;

  logic clk, nrst, order, reg_wr, reg_rd, data_oe, act, wr, eo, wlast, s, l;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  ssb_pins_s pins;
  ssb_word_t data_out, ed, mask, mem [DEPTH];
  ssb_addr_t base, adr;
  logic [1:0] cnt;
  logic [DATA_W:0] expq [$];
  int mismatches, check_count;

  ssb_ctrl dut_u (.clk(clk), .nrst(nrst), .pins(pins), .data_out(data_out),
    .data_oe(data_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ssb_ctl_model ctl_u (.clk(clk), .order(order), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs are compared three cycles after the pins that cause them.
  always @(negedge clk) begin
    logic mo;
    ssb_word_t md;
    if (expq.size() > 4) begin
      {mo, md} = expq.pop_front();
      `CHK(data_oe, mo)
      if (mo) `CHK(data_out, md)
    end
  end

  task automatic op(input logic ce_n, input logic ld_n, input logic rw_n, input logic cs_n,
      input ssb_addr_t a, input logic [LANES-1:0] bw);
    ssb_word_t wd, wm;
    wd = ssb_word_t'({$urandom, $urandom});
    wm = wd & mask;
    if (!ce_n) begin
      if (!ld_n) begin
        act = !cs_n;
        wr = !rw_n;
        base = a;
        cnt = 2'h0;
      end else begin
        cnt = cnt + 2'h1;
      end
      adr = {base[3:2], order ? base[1:0] ^ cnt : base[1:0] + cnt};
      for (int i = 0; i < LANES; i++) begin
        if (act && wr && !bw[i]) begin
          mem[adr][i*LANE_W +: LANE_W] = wm[i*LANE_W +: LANE_W];
        end
      end
      eo = act && !wr;
      if (eo) ed = mem[adr];
    end
    expq.push_back({eo, ed});
    wlast = !ce_n && act && wr;
    ctl_u.cycle(ce_n, ld_n, rw_n, cs_n, a, bw, wd);
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset, registers, a full write fill, then random bursts with stalls.
  task automatic phase(input logic ord, input logic wid);
    @(posedge clk);
    nrst <= 1'b0;
    order <= ord;
    expq.delete();
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    {act, wr, cnt, eo, ed, wlast} = '0;
    mask = wid ? '1 : ~ssb_word_t'(36'h804020100);
    repeat (3) @(posedge clk);
    reg_read(REG_CTRL, 32'h0);
    reg_write(REG_CTRL, {31'h0, wid});
    reg_read(REG_CTRL, {31'h0, wid});
    reg_read(4'h8, 32'h0);
    for (int b = 0; b < 4; b++) begin
      op(1'b0, 1'b0, 1'b0, 1'b0, ssb_addr_t'(b * 4), 4'h0);
      repeat (3) op(1'b0, 1'b1, 1'b1, 1'b0, 4'($urandom_range(15)), 4'h0);
    end
    op(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'hF);
    repeat (4) op(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
    reg_read(REG_STATUS, {26'h0, wid, ord, 4'h8});
    op(1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 4'hF);
    repeat (5) op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
    for (int k = 0; k < 400; k++) begin
      s = !wlast && ($urandom_range(7) == 0);
      l = ($urandom_range(1) == 0) || (cnt == 2'h3);
      op(s, !l, 1'($urandom_range(1)), $urandom_range(7) == 0, 4'($urandom_range(15)),
        4'($urandom_range(15)));
    end
    repeat (4) op(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
    $display("test order=%0d wide=%0d done", ord, wid);
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #20000;
    mismatches++;
    complete_run();
  end

  initial begin
    nrst = 1'b0;
    order = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    void'($urandom(32'h53fcf562));
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b1);
    complete_run();
  end
endmodule

// ===== design/ssb_ctrl.sv
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
module ssb_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Memory controller pins.
  input wire ssb_pkg::ssb_pins_s pins,
  output logic [ssb_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import ssb_pkg::*;

  ssb_state_s st_q;
  ssb_state_s st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic run;
  logic load;
  ssb_pins_s s;

  ////////////////////////////////////////////////////////////////////////////
  // Burst address step for either order.
  function automatic logic [1:0] burst_lsb(input logic interleave, input logic [1:0] start,
                                           input logic [1:0] count);
    if (interleave) begin
      burst_lsb = start ^ count;
    end else begin
      burst_lsb = start + count;
    end
  endfunction

  function automatic ssb_addr_t burst_addr(input ssb_core_s c, input logic interleave);
    burst_addr = {c.base[ADDR_W-1:2], burst_lsb(interleave, c.start, c.count)};
  endfunction

  assign rst_n = rst_sync_q[1];
  assign s = st_q.pin_sync;
  assign run = ~s.clock_enable_n;
  assign load = ~s.advance_or_load_n;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    ssb_core_s c;
    ssb_addr_t na;
    c = st_q.core;
    na = '0;
    st_d = st_q;
    st_d.pin_meta = pins;
    st_d.pin_sync = st_q.pin_meta;
    // Freeze the whole burst engine while the clock enable is inactive.
    if (run) begin
      // Complete the write whose lanes were taken with the address.
      if (c.wr_pend) begin
        for (int i = 0; i < LANES; i++) begin
          if (!c.wr_lanes_n[i]) begin
            c.mem[c.wr_addr][i*LANE_W +: LANE_W] = s.data[i*LANE_W +: LANE_W];
            if (!st_q.wide) begin
              c.mem[c.wr_addr][i*LANE_W + EXTRA_BIT] = 1'b0;
            end
          end
        end
      end
      if (load) begin
        c.active = ~s.chip_select_n;
        c.is_write = ~s.read_write_n;
        c.base = s.address;
        c.start = s.address[1:0];
        c.count = 2'h0;
      end else begin
        c.count = c.count + 2'h1;
      end
      na = burst_addr(c, s.burst_order_select);
      c.wr_pend = c.active & c.is_write;
      c.wr_addr = na;
      c.wr_lanes_n = s.lane_write_enable_n;
      c.out_en = c.active & ~c.is_write;
      if (c.active && !c.is_write) begin
        c.dout = c.mem[na];
      end
    end
    st_d.core = c;
    st_d.rdata = 32'h0;
    if (reg_wr && reg_addr == REG_CTRL) begin
      st_d.wide = reg_wdata[CTRL_WIDE_BIT];
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: st_d.rdata[CTRL_WIDE_BIT] = st_q.wide;
        REG_STATUS: begin
          st_d.rdata[STAT_LSB_POS +: 2] = burst_lsb(s.burst_order_select, st_q.core.start,
                                                    st_q.core.count);
          st_d.rdata[STAT_WRITE_BIT] = st_q.core.is_write;
          st_d.rdata[STAT_ACTIVE_BIT] = st_q.core.active;
          st_d.rdata[STAT_ORDER_BIT] = s.burst_order_select;
          st_d.rdata[STAT_WIDE_BIT] = st_q.wide;
        end
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and state register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.pin_meta <= PINS_IDLE;
      st_q.pin_sync <= PINS_IDLE;
      st_q.core <= '0;
      st_q.wide <= CTRL_WIDE_RST;
      st_q.rdata <= 32'h0;
    end else begin
      st_q.pin_meta <= st_d.pin_meta;
      st_q.pin_sync <= st_d.pin_sync;
      st_q.core <= st_d.core;
      st_q.wide <= st_d.wide;
      st_q.rdata <= st_d.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, extra bits masked when narrow.
  always_comb begin
    data_out = st_q.core.dout;
    for (int i = 0; i < LANES; i++) begin
      if (!st_q.wide) begin
        data_out[i*LANE_W + EXTRA_BIT] = 1'b0;
      end
    end
  end
  assign data_oe = st_q.core.out_en;
  assign reg_rdata = st_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_load;
    run && load;
  endsequence

  sequence s_advance;
    run && !load;
  endsequence

  property p_rw_select;
    s_load |=> st_q.core.is_write == !$past(s.read_write_n);
  endproperty
  a_rw_select: assert property (p_rw_select) else $error("cycle type not taken at load");

  property p_type_hold;
    !(run && load) |=> $stable(st_q.core.is_write);
  endproperty
  a_type_hold: assert property (p_type_hold) else $error("cycle type changed mid burst");

  property p_stall;
    !run |=> $stable(st_q.core);
  endproperty
  a_stall: assert property (p_stall) else $error("state moved during stall");

  property p_load_addr;
    s_load |=> st_q.core.base == $past(s.address) && st_q.core.count == 2'h0;
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("address not loaded");

  property p_linear;
    s_advance ##0 !s.burst_order_select |=>
      st_q.core.wr_addr[1:0] == st_q.core.start + st_q.core.count;
  endproperty
  a_linear: assert property (p_linear) else $error("linear step wrong");

  property p_interleave;
    s_advance ##0 s.burst_order_select |=>
      st_q.core.wr_addr[1:0] == (st_q.core.start ^ st_q.core.count);
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave step wrong");

  property p_burst_wrap;
    s_load ##1 s_advance [*4] |=> st_q.core.count == 2'h0;
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) else $error("burst counter did not wrap");

  property p_read_oe;
    s_load ##0 !s.chip_select_n ##0 s.read_write_n |=> data_oe;
  endproperty
  a_read_oe: assert property (p_read_oe) else $error("read did not drive data");

  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      property p_lane_write;
        run && st_q.core.wr_pend && !st_q.core.wr_lanes_n[g] |=>
          st_q.core.mem[$past(st_q.core.wr_addr)][g*LANE_W +: EXTRA_BIT] ==
          $past(s.data[g*LANE_W +: EXTRA_BIT]);
      endproperty
      a_lane_write: assert property (p_lane_write) else $error("lane not written");

      property p_lane_keep;
        run && st_q.core.wr_pend && st_q.core.wr_lanes_n[g] |=>
          st_q.core.mem[$past(st_q.core.wr_addr)][g*LANE_W +: LANE_W] ==
          $past(st_q.core.mem[st_q.core.wr_addr][g*LANE_W +: LANE_W]);
      endproperty
      a_lane_keep: assert property (p_lane_keep) else $error("disabled lane written");

      property p_extra_zero;
        !st_q.wide |-> !data_out[g*LANE_W + EXTRA_BIT];
      endproperty
      a_extra_zero: assert property (p_extra_zero) else $error("extra bit used narrow");

      property p_extra_store;
        run && st_q.core.wr_pend && !st_q.core.wr_lanes_n[g] |=>
          st_q.core.mem[$past(st_q.core.wr_addr)][g*LANE_W + EXTRA_BIT] ==
          ($past(s.data[g*LANE_W + EXTRA_BIT]) && $past(st_q.wide));
      endproperty
      a_extra_store: assert property (p_extra_store) else $error("extra bit wrong");
    end
  endgenerate

  property p_enable_follow;
    s_load ##0 !s.chip_select_n ##0 !s.read_write_n |=>
      st_q.core.wr_pend && st_q.core.wr_lanes_n == $past(s.lane_write_enable_n);
  endproperty
  a_enable_follow: assert property (p_enable_follow) else $error("lanes not taken");

  sequence s_write_cont;
    s_advance ##0 st_q.core.active && st_q.core.is_write;
  endsequence

  sequence s_read_cont;
    s_advance ##0 st_q.core.active && !st_q.core.is_write;
  endsequence

  property p_deselect;
    s_load ##0 s.chip_select_n |=> !st_q.core.active && !data_oe && !st_q.core.wr_pend;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect still active");

  property p_write_no_oe;
    s_load ##0 !s.read_write_n |=> !data_oe;
  endproperty
  a_write_no_oe: assert property (p_write_no_oe) else $error("write drove data");

  property p_write_cont;
    s_write_cont |=> st_q.core.wr_pend && !data_oe &&
      st_q.core.wr_lanes_n == $past(s.lane_write_enable_n);
  endproperty
  a_write_cont: assert property (p_write_cont) else $error("write burst lost type");

  property p_read_cont;
    s_read_cont |=> data_oe && !st_q.core.wr_pend;
  endproperty
  a_read_cont: assert property (p_read_cont) else $error("read burst lost type");

  property p_count_step;
    s_advance |=> st_q.core.count == $past(st_q.core.count) + 2'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_start_hold;
    s_advance |=> $stable(st_q.core.start) && $stable(st_q.core.base);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("burst base moved");

  property p_load_lsb;
    s_load |=> st_q.core.wr_addr == $past(s.address);
  endproperty
  a_load_lsb: assert property (p_load_lsb) else $error("first burst address wrong");

  property p_read_data;
    s_load ##0 !s.chip_select_n ##0 s.read_write_n ##0 !st_q.core.wr_pend |=>
      st_q.core.dout == $past(st_q.core.mem[s.address]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  property p_no_write_idle;
    run && !st_q.core.wr_pend |=> $stable(st_q.core.mem);
  endproperty
  a_no_write_idle: assert property (p_no_write_idle) else $error("memory changed");

  property p_rdata_ctrl;
    reg_rd && reg_addr == REG_CTRL |=> reg_rdata == {31'h0, $past(st_q.wide)};
  endproperty
  a_rdata_ctrl: assert property (p_rdata_ctrl) else $error("control read wrong");

  property p_rdata_status;
    reg_rd && reg_addr == REG_STATUS |=>
      reg_rdata[STAT_ORDER_BIT] == $past(s.burst_order_select) &&
      reg_rdata[STAT_ACTIVE_BIT] == $past(st_q.core.active);
  endproperty
  a_rdata_status: assert property (p_rdata_status) else $error("status read wrong");

endmodule

// ===== design/ssb_pkg.sv
package ssb_pkg;

  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int EXTRA_BIT = 8;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;

  // Register port map and field positions.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_WIDE_BIT = 0;
  localparam logic CTRL_WIDE_RST = 1'b0;
  localparam int STAT_LSB_POS = 0;
  localparam int STAT_WRITE_BIT = 2;
  localparam int STAT_ACTIVE_BIT = 3;
  localparam int STAT_ORDER_BIT = 4;
  localparam int STAT_WIDE_BIT = 5;

  typedef logic [DATA_W-1:0] ssb_word_t;
  typedef logic [ADDR_W-1:0] ssb_addr_t;

  // Synchronous pins from the memory controller.
  typedef struct packed {
    logic clock_enable_n;
    logic advance_or_load_n;
    logic chip_select_n;
    logic read_write_n;
    logic [LANES-1:0] lane_write_enable_n;
    logic burst_order_select;
    ssb_addr_t address;
    ssb_word_t data;
  } ssb_pins_s;

  // Sync stages reset to a stalled, deselected pin set so no false cycle follows reset.
  localparam ssb_pins_s PINS_IDLE = '{clock_enable_n: 1'b1, advance_or_load_n: 1'b1,
    chip_select_n: 1'b1, read_write_n: 1'b1, lane_write_enable_n: '1,
    burst_order_select: 1'b1, address: '0, data: '0};

  // Burst engine state, frozen by the clock enable.
  typedef struct packed {
    logic active;
    logic is_write;
    ssb_addr_t base;
    logic [1:0] start;
    logic [1:0] count;
    logic wr_pend;
    ssb_addr_t wr_addr;
    logic [LANES-1:0] wr_lanes_n;
    logic out_en;
    ssb_word_t dout;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
  } ssb_core_s;

  typedef struct packed {
    ssb_pins_s pin_meta;
    ssb_pins_s pin_sync;
    ssb_core_s core;
    logic wide;
    logic [31:0] rdata;
  } ssb_state_s;

endpackage
